/* File: logic/deglitch_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module deglitch_timer (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       cond_i,
  input  wire logic [7:0] limit_i,
  output logic            hit_o
);
  gdfm_pkg::deg_state_t state_q;
  gdfm_pkg::deg_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (!cond_i) begin
      state_d.cnt = 8'h00;
      state_d.hit = 1'b0;
    end else if (state_q.cnt >= limit_i) begin
      state_d.hit = 1'b1;
    end else begin
      state_d.cnt = state_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign hit_o = state_q.hit;
endmodule
`default_nettype wire

/* File: logic/fault_monitor_dev.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gdfm_regs.svh"
module fault_monitor_dev (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  gdfm_if.dev              ifc,
  input  wire logic        drain_ov_i,
  input  wire logic [5:0]  vgs_high_i,
  input  wire logic [5:0]  vds_over_i,
  input  wire logic [2:0]  shunt_over_i,
  input  wire logic [2:0]  phase_cmp_i,
  input  wire logic        thermal_shutdown_i,
  input  wire logic        thermal_warning_i,
  input  wire logic [63:0] otp_data_i,
  input  wire logic [7:0]  otp_crc_i,
  output logic [2:0]       gate_hs_o,
  output logic [2:0]       gate_ls_o,
  output logic             pump_en_o,
  output logic             boot_charge_en_o,
  output logic             csa_en_o,
  output logic             gate_reg_en_o,
  output logic [2:0]       diag_src_o,
  output logic [2:0]       diag_snk_o,
  output logic [1:0]       drain_ov_lvl_o,
  output logic             crc_done_o,
  output logic             asleep_o
);
  gdfm_pkg::dev_state_t state_q;
  gdfm_pkg::dev_state_t state_d;
  gdfm_pkg::pins_t      pins;

  logic [18:0]      cond;
  logic [18:0]      hit;
  logic [18:0][7:0] lim;
  logic [5:0]       drv;
  logic [5:0]       edge_seen;
  logic [5:0]       vgs_c;
  logic [7:0]       blk_l;
  logic [2:0]       ls_cmd;
  logic [15:0]      stat1;
  logic [15:0]      stat2;
  logic [15:0]      rd;
  logic [5:0]       vds_rep;
  logic             diag;
  logic             cmp_out;
  logic             clr;
  logic             tsd_shut;
  logic             hard;
  logic             gate_off;
  logic             wdt_set;
  logic [7:0]       crc_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] step_lim(input logic [3:0] f);
    return 8'(({4'h0, f} + 8'h01) * 8'(`DEG_STEP_CYC));
  endfunction

  function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `OTP_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------
  // Monitor conditions
  // ----------------------------------------
  assign pins = state_q.s2;
  assign diag = |{state_q.cfg2[`CFG2_SRC_LO +: 3], state_q.cfg2[`CFG2_SNK_LO +: 3]};
  assign cmp_out = state_q.cfg3[`CFG3_CMP_OUT];
  assign drv = {state_q.gate_ls, state_q.gate_hs};
  assign edge_seen = drv ^ state_q.prev;
  assign blk_l = step_lim(state_q.cfg1[`CFG1_BLK_LO +: 4]);

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_vgs
      assign vgs_c[g] = (state_q.blank[g] >= blk_l) & ~edge_seen[g] &
                        (drv[g] ? ~pins.vgs_hi[g] : pins.vgs_hi[g]);
    end
    for (g = 0; g < 19; g++) begin : g_deg
      deglitch_timer u_deg (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cond_i   (cond[g]),
        .limit_i  (lim[g]),
        .hit_o    (hit[g])
      );
    end
  endgenerate

  assign cond = {pins.drain_ov, {3{cmp_out}} & (pins.hs_pin ^ pins.phc), pins.shunt,
                 pins.vds, vgs_c};
  assign lim = {8'(`OV_DG_CYC), {3{step_lim(state_q.cfg1[`CFG1_VGS_LO +: 4])}},
                {3{step_lim(state_q.cfg1[`CFG1_SEN_LO +: 4])}},
                {6{step_lim(state_q.cfg1[`CFG1_VDS_LO +: 4])}},
                {6{step_lim(state_q.cfg1[`CFG1_VGS_LO +: 4])}}};

  // Three-input mode takes low-side command from SPI enables
  assign ls_cmd = (state_q.cfg3[`CFG3_MODE_LO +: 3] == `PWM_MODE_3X_SPI) ?
                  (~pins.hs_pin & state_q.cfg3[`CFG3_LSEN_LO +: 3]) : pins.ls_pin;
  assign vds_rep = diag ? pins.vds : state_q.vds_f;
  assign stat1 = {~state_q.fault_n, 6'h00, state_q.phc_f, |state_q.sen_f, state_q.crc_fail,
                  state_q.wdt_f, state_q.otw_f, state_q.tsd_f, state_q.ov_f};
  assign stat2 = {1'b0, state_q.sen_f, vds_rep, state_q.vgs_f};
  assign clr = ifc.spi_valid & ifc.spi_wr & (ifc.spi_addr == `ADDR_CMD) &
               ifc.spi_wdata[`CMD_CLR];
  assign tsd_shut = state_q.tsd_f & ~state_q.cfg2[`CFG2_TSD_RESP];
  assign hard = state_q.ov_f | tsd_shut | state_q.asleep;
  assign gate_off = hard | (|state_q.vds_f) | (|state_q.sen_f) |
                    (diag & ~state_q.cfg2[`CFG2_DRV_ALLOW]);
  assign crc_next = crc8_byte(state_q.crc, otp_data_i[{state_q.crc_idx, 3'b000} +: 8]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.s1 = {ifc.sleep_n, ifc.ls_level, ifc.hs_in, thermal_warning_i,
                  thermal_shutdown_i, phase_cmp_i, shunt_over_i, vds_over_i, vgs_high_i,
                  drain_ov_i};
    state_d.s2 = state_q.s1;
    rd = 16'h0000;
    wdt_set = 1'b0;

    // Register access, write answers with old contents
    case (ifc.spi_addr)
      `ADDR_STAT1: rd = stat1;
      `ADDR_STAT2: rd = stat2;
      `ADDR_CFG1: rd = state_q.cfg1;
      `ADDR_CFG2: rd = state_q.cfg2;
      `ADDR_CFG3: rd = state_q.cfg3;
      default: rd = 16'h0000;
    endcase
    state_d.rvalid = ifc.spi_valid;
    if (ifc.spi_valid) begin
      state_d.rdata = rd;
    end
    if (ifc.spi_valid & ifc.spi_wr) begin
      case (ifc.spi_addr)
        `ADDR_CFG1: state_d.cfg1 = ifc.spi_wdata;
        `ADDR_CFG2: state_d.cfg2 = ifc.spi_wdata;
        `ADDR_CFG3: state_d.cfg3 = ifc.spi_wdata;
        default: state_d.cfg1 = state_q.cfg1;
      endcase
    end

    // Blanking restarts on every drive edge
    state_d.prev = drv;
    for (int k = 0; k < 6; k++) begin
      if (edge_seen[k]) begin
        state_d.blank[k] = 8'h00;
      end else if (state_q.blank[k] < blk_l) begin
        state_d.blank[k] = state_q.blank[k] + 8'h01;
      end
    end

    // Watchdog window
    if (!state_q.cfg2[`CFG2_WATCHDOG_ENABLE_BIT]) begin
      state_d.wdt_cnt = 12'h000;
    end else if (ifc.spi_valid) begin
      wdt_set = (state_q.wdt_cnt < 12'(`WDT_LO_CYC));
      state_d.wdt_cnt = 12'h000;
    end else if (state_q.wdt_cnt >= 12'(`WDT_HI_CYC)) begin
      wdt_set = 1'b1;
      state_d.wdt_cnt = 12'h000;
    end else begin
      state_d.wdt_cnt = state_q.wdt_cnt + 12'h001;
    end

    // Sticky flags, a new event beats a clear
    state_d.ov_f = (state_q.ov_f & ~clr) | hit[18];
    state_d.tsd_f = (state_q.tsd_f & ~clr) | pins.tsd;
    state_d.otw_f = (state_q.otw_f & ~clr) | pins.thermal_warning;
    state_d.wdt_f = (state_q.wdt_f & ~clr) | wdt_set;
    state_d.vgs_f = (state_q.vgs_f & ~{6{clr}}) | hit[5:0];
    state_d.vds_f = (state_q.vds_f & ~{6{clr}}) | (hit[11:6] & ~{6{diag}});
    state_d.sen_f = (state_q.sen_f & ~{3{clr}}) | hit[14:12];
    state_d.phc_f = (state_q.phc_f & ~{3{clr}}) | hit[17:15];

    // Sleep entry after delay, wake at once
    if (pins.sleep_n) begin
      state_d.asleep = 1'b0;
      state_d.sleep_cnt = 8'h00;
    end else if (!state_q.asleep) begin
      if (state_q.sleep_cnt >= 8'(`SLEEP_CYC - 1)) begin
        state_d.asleep = 1'b1;
      end else begin
        state_d.sleep_cnt = state_q.sleep_cnt + 8'h01;
      end
    end

    // OTP checksum pass after reset
    case (state_q.crc_st)
      gdfm_pkg::CRC_RUN: begin
        state_d.crc = crc_next;
        state_d.crc_idx = state_q.crc_idx + 3'h1;
        if (state_q.crc_idx == 3'(`OTP_BYTES - 1)) begin
          state_d.crc_st = gdfm_pkg::CRC_DONE;
          state_d.crc_fail = (crc_next != otp_crc_i);
        end
      end
      gdfm_pkg::CRC_DONE: state_d.crc_st = gdfm_pkg::CRC_DONE;
      default: state_d.crc_st = gdfm_pkg::CRC_RUN;
    endcase

    // Outputs
    state_d.gate_hs = pins.hs_pin & ~{3{gate_off}};
    state_d.gate_ls = ls_cmd & ~{3{gate_off}};
    state_d.pump_en = ~hard;
    state_d.boot_en = ~hard & ~diag;
    state_d.csa_en = ~(tsd_shut | state_q.asleep);
    state_d.greg_en = ~state_q.asleep;
    state_d.src = state_q.cfg2[`CFG2_SRC_LO +: 3] & ~{3{state_q.asleep}};
    state_d.snk = state_q.cfg2[`CFG2_SNK_LO +: 3] & ~{3{state_q.asleep}};
    state_d.fault_n = ~(state_q.ov_f | tsd_shut | state_q.wdt_f | (|state_q.vgs_f) |
                        (|state_q.vds_f) | (|state_q.sen_f));
    state_d.ls_drv = pins.phc;
    state_d.ls_oe = cmp_out;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= '0;
      state_q.s1.sleep_n <= 1'b1;
      state_q.s2.sleep_n <= 1'b1;
      state_q.cfg1 <= `CFG1_RST;
      state_q.cfg2 <= `CFG2_RST;
      state_q.cfg3 <= `CFG3_RST;
      state_q.crc <= `OTP_CRC_INIT;
      state_q.crc_st <= gdfm_pkg::CRC_RUN;
      state_q.fault_n <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign gate_hs_o = state_q.gate_hs;
  assign gate_ls_o = state_q.gate_ls;
  assign pump_en_o = state_q.pump_en;
  assign boot_charge_en_o = state_q.boot_en;
  assign csa_en_o = state_q.csa_en;
  assign gate_reg_en_o = state_q.greg_en;
  assign diag_src_o = state_q.src;
  assign diag_snk_o = state_q.snk;
  assign drain_ov_lvl_o = state_q.cfg2[`CFG2_OV_LVL_LO +: 2];
  assign crc_done_o = (state_q.crc_st == gdfm_pkg::CRC_DONE);
  assign asleep_o = state_q.asleep;
  assign ifc.fault_n = state_q.fault_n;
  assign ifc.spi_rdata = state_q.rdata;
  assign ifc.spi_rvalid = state_q.rvalid;
  assign ifc.ls_dev = state_q.ls_drv;
  assign ifc.ls_dev_oe = {3{state_q.ls_oe}};
endmodule
`default_nettype wire

/* File: logic/fault_monitor_mcu.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gdfm_regs.svh"
module fault_monitor_mcu (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  gdfm_if.host             ifc,
  input  wire logic        req_valid_i,
  input  wire logic        req_wr_i,
  input  wire logic [6:0]  req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  input  wire logic [2:0]  pwm_hs_i,
  input  wire logic [2:0]  pwm_ls_i,
  input  wire logic        sleep_req_i,
  output logic             drive_ready_o,
  output logic             fault_o,
  output logic [2:0]       phase_cmp_o
);
  gdfm_pkg::host_state_t state_q;
  gdfm_pkg::host_state_t state_d;

  logic        issue_user;
  logic        issue_keep;
  logic [15:0] wdata;
  logic        diag_new;

  assign issue_user = req_valid_i & state_q.ready;
  assign issue_keep = ~req_valid_i & state_q.ready & state_q.watchdog_enable_bit &
                      (state_q.since >= 12'(`WDT_KEEP_CYC));
  // Comparator outputs need the three-input SPI low-side mode
  assign wdata = (req_addr_i == `ADDR_CFG3 && req_wdata_i[`CFG3_CMP_OUT]) ?
                 {req_wdata_i[15:3], `PWM_MODE_3X_SPI} : req_wdata_i;
  assign diag_new = |{req_wdata_i[`CFG2_SRC_LO +: 3], req_wdata_i[`CFG2_SNK_LO +: 3]};

  always_comb begin
    state_d = state_q;
    state_d.s1 = {ifc.fault_n, ifc.ls_level};
    state_d.s2 = state_q.s1;
    state_d.valid = issue_user | issue_keep;
    state_d.rsp_valid = ifc.spi_rvalid & ~state_q.internal;
    state_d.since = (state_q.since == 12'hFFF) ? state_q.since : state_q.since + 12'h001;
    if (ifc.spi_rvalid) begin
      state_d.busy = 1'b0;
      state_d.rsp_data = ifc.spi_rdata;
    end
    if (issue_user | issue_keep) begin
      state_d.busy = 1'b1;
      state_d.internal = issue_keep;
      state_d.since = 12'h000;
      state_d.wr = issue_user & req_wr_i;
      state_d.addr = issue_user ? req_addr_i : `ADDR_STAT1;
      state_d.wdata = wdata;
    end
    if (issue_user & req_wr_i & (req_addr_i == `ADDR_CFG2)) begin
      state_d.watchdog_enable_bit = req_wdata_i[`CFG2_WATCHDOG_ENABLE_BIT];
      state_d.diag_on = diag_new;
      if (state_q.diag_on & ~diag_new) begin
        state_d.pre_cnt = 8'(`PRECHG_CYC);
      end
    end
    if (issue_user & req_wr_i & (req_addr_i == `ADDR_CFG3)) begin
      state_d.cmp_mode = req_wdata_i[`CFG3_CMP_OUT];
    end
    // Hold off until the lower window has passed
    state_d.ready = ~state_d.busy & state_q.awake &
                    (~state_d.watchdog_enable_bit | (state_d.since > 12'(`WDT_LO_CYC)));
    if (state_q.pre_cnt != 8'h00) begin
      state_d.pre_cnt = state_q.pre_cnt - 8'h01;
    end
    state_d.sleep_n = ~sleep_req_i;
    if (sleep_req_i) begin
      state_d.awake = 1'b0;
      state_d.wake_cnt = 8'h00;
    end else if (state_q.wake_cnt < 8'(`WAKE_CYC)) begin
      state_d.wake_cnt = state_q.wake_cnt + 8'h01;
    end else begin
      state_d.awake = 1'b1;
    end
    state_d.drive_ok = state_q.awake & (state_q.pre_cnt == 8'h00);
    state_d.hs = state_q.drive_ok ? pwm_hs_i : 3'h0;
    state_d.ls = (state_q.pre_cnt != 8'h00) ? 3'h7 : (state_q.drive_ok ? pwm_ls_i : 3'h0);
    state_d.ls_oe = state_q.cmp_mode ? 3'h0 : 3'h7;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= '0;
      state_q.s1 <= 4'h8;
      state_q.s2 <= 4'h8;
      state_q.ls_oe <= 3'h7;
    end else begin
      state_q <= state_d;
    end
  end

  assign req_ready_o = state_q.ready;
  assign rsp_valid_o = state_q.rsp_valid;
  assign rsp_data_o = state_q.rsp_data;
  assign drive_ready_o = state_q.drive_ok;
  assign fault_o = ~state_q.s2[3];
  assign phase_cmp_o = state_q.s2[2:0];
  assign ifc.hs_in = state_q.hs;
  assign ifc.ls_host = state_q.ls;
  assign ifc.ls_host_oe = state_q.ls_oe;
  assign ifc.sleep_n = state_q.sleep_n;
  assign ifc.spi_valid = state_q.valid;
  assign ifc.spi_wr = state_q.wr;
  assign ifc.spi_addr = state_q.addr;
  assign ifc.spi_wdata = state_q.wdata;
endmodule
`default_nettype wire

/* File: logic/gdfm_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface gdfm_if;
  logic [2:0]  hs_in;
  logic [2:0]  ls_host;
  logic [2:0]  ls_host_oe;
  logic [2:0]  ls_dev;
  logic [2:0]  ls_dev_oe;
  logic [2:0]  ls_level;
  logic        sleep_n;
  logic        fault_n;
  logic        spi_valid;
  logic        spi_wr;
  logic [6:0]  spi_addr;
  logic [15:0] spi_wdata;
  logic [15:0] spi_rdata;
  logic        spi_rvalid;

  // Shared low-side pins, weak pull-down when nobody drives
  assign ls_level = (ls_dev_oe & ls_dev) | (~ls_dev_oe & ls_host_oe & ls_host);

  modport dev (input hs_in, ls_level, sleep_n, spi_valid, spi_wr, spi_addr, spi_wdata,
               output ls_dev, ls_dev_oe, fault_n, spi_rdata, spi_rvalid);
  modport host (input ls_level, fault_n, spi_rdata, spi_rvalid,
                output hs_in, ls_host, ls_host_oe, sleep_n, spi_valid, spi_wr, spi_addr,
                spi_wdata);
endinterface
`default_nettype wire

/* File: logic/gdfm_pkg.sv */
`default_nettype none
package gdfm_pkg;
  typedef enum logic [0:0] {CRC_RUN, CRC_DONE} crc_state_t;

  typedef struct packed {
    logic       sleep_n;
    logic [2:0] ls_pin;
    logic [2:0] hs_pin;
    logic       thermal_warning;
    logic       tsd;
    logic [2:0] phc;
    logic [2:0] shunt;
    logic [5:0] vds;
    logic [5:0] vgs_hi;
    logic       drain_ov;
  } pins_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       hit;
  } deg_state_t;

  typedef struct packed {
    pins_t           s1;
    pins_t           s2;
    logic [15:0]     cfg1;
    logic [15:0]     cfg2;
    logic [15:0]     cfg3;
    logic [15:0]     rdata;
    logic            rvalid;
    logic            ov_f;
    logic            tsd_f;
    logic            otw_f;
    logic            wdt_f;
    logic            crc_fail;
    logic [5:0]      vgs_f;
    logic [5:0]      vds_f;
    logic [2:0]      sen_f;
    logic [2:0]      phc_f;
    logic [5:0][7:0] blank;
    logic [5:0]      prev;
    logic [7:0]      sleep_cnt;
    logic            asleep;
    logic [11:0]     wdt_cnt;
    crc_state_t      crc_st;
    logic [2:0]      crc_idx;
    logic [7:0]      crc;
    logic [2:0]      gate_hs;
    logic [2:0]      gate_ls;
    logic            pump_en;
    logic            boot_en;
    logic            csa_en;
    logic            greg_en;
    logic [2:0]      src;
    logic [2:0]      snk;
    logic            fault_n;
    logic [2:0]      ls_drv;
    logic            ls_oe;
  } dev_state_t;

  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic        ready;
    logic        busy;
    logic        internal;
    logic        valid;
    logic        wr;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        watchdog_enable_bit;
    logic [11:0] since;
    logic        cmp_mode;
    logic        diag_on;
    logic [7:0]  pre_cnt;
    logic [7:0]  wake_cnt;
    logic        awake;
    logic        sleep_n;
    logic [2:0]  hs;
    logic [2:0]  ls;
    logic [2:0]  ls_oe;
    logic        drive_ok;
  } host_state_t;
endpackage
`default_nettype wire

/* File: logic/gdfm_regs.svh */
`ifndef GDFM_REGS_SVH
`define GDFM_REGS_SVH
// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define ADDR_STAT1 7'h00
`define ADDR_STAT2 7'h01
`define ADDR_CFG1 7'h10
`define ADDR_CFG2 7'h11
`define ADDR_CFG3 7'h12
`define ADDR_CMD 7'h13
`define CFG1_RST 16'h3333
`define CFG2_RST 16'h0000
`define CFG3_RST 16'h0000
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG1_BLK_LO 0
`define CFG1_VGS_LO 4
`define CFG1_VDS_LO 8
`define CFG1_SEN_LO 12
`define CFG2_WATCHDOG_ENABLE_BIT 0
`define CFG2_TSD_RESP 1
`define CFG2_OV_LVL_LO 2
`define CFG2_DRV_ALLOW 4
`define CFG2_SRC_LO 5
`define CFG2_SNK_LO 8
`define CFG3_MODE_LO 0
`define CFG3_CMP_OUT 3
`define CFG3_LSEN_LO 4
`define PWM_MODE_3X_SPI 3'h2
`define CMD_CLR 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 125
`define DEG_STEP_NS 64
`define DEG_STEP_CYC ((`DEG_STEP_NS * `CLK_MHZ + 999) / 1000)
`define OV_DG_NS 1000
`define OV_DG_CYC ((`OV_DG_NS * `CLK_MHZ + 999) / 1000)
`define SLEEP_NS 1000
`define SLEEP_CYC ((`SLEEP_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_NS 1000
`define WAKE_CYC ((`WAKE_NS * `CLK_MHZ + 999) / 1000)
`define PRECHG_NS 2000
`define PRECHG_CYC ((`PRECHG_NS * `CLK_MHZ + 999) / 1000)
`define WDT_LO_NS 2000
`define WDT_LO_CYC ((`WDT_LO_NS * `CLK_MHZ + 999) / 1000)
`define WDT_HI_NS 20000
`define WDT_HI_CYC ((`WDT_HI_NS * `CLK_MHZ) / 1000)
`define WDT_KEEP_CYC ((`WDT_LO_CYC + `WDT_HI_CYC) / 2)
`define OTP_BYTES 8
`define OTP_CRC_POLY 8'h07
`define OTP_CRC_INIT 8'hFF
`endif

/* File: sim/gate_driver_fault_monitor_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module gate_driver_fault_monitor_bench;
  logic        clk_i, resetn_i, req_valid_i, req_wr_i, req_ready_o, rsp_valid_o, sleep_req_i;
  logic        drive_ready_o, fault_o, drain_ov_i, thermal_shutdown_i, thermal_warning_i;
  logic        pump_en_o, boot_charge_en_o, csa_en_o, gate_reg_en_o, crc_done_o, asleep_o;
  logic [1:0]  drain_ov_lvl_o;
  logic [2:0]  pwm_hs_i, pwm_ls_i, phase_cmp_o, shunt_over_i, phase_cmp_i;
  logic [2:0]  gate_hs_o, gate_ls_o, diag_src_o, diag_snk_o;
  logic [5:0]  vgs_high_i, vds_over_i, vgs_err;
  logic [6:0]  req_addr_i;
  logic [7:0]  otp_crc_i;
  logic [15:0] req_wdata_i, rsp_data_o, rd;
  logic [63:0] otp_data_i;
  int          fails, checks, cyc;
  localparam logic [15:0] msk [6] = '{16'h1, 16'h200, 16'h20, 16'h2, 16'h1, 16'h4};
  gdfm_if ifc ();
  fault_monitor_dev i_fault_monitor_dev (.*);
  fault_monitor_mcu i_fault_monitor_mcu (.*);
  gdfm_assertions i_gdfm_assertions (.clk_i, .resetn_i, .hs_in(ifc.hs_in),
    .ls_dev_oe(ifc.ls_dev_oe), .sleep_n(ifc.sleep_n), .spi_valid(ifc.spi_valid),
    .spi_wr(ifc.spi_wr), .spi_addr(ifc.spi_addr), .spi_wdata(ifc.spi_wdata),
    .spi_rvalid(ifc.spi_rvalid));
  // ----------------------------------------
  // Clock, gate-voltage model, timeout, tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) vgs_high_i <= {gate_ls_o, gate_hs_o} ^ vgs_err;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic wr, input logic [6:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_wr_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    // Hold the request until ready is seen at a taking edge
    do begin
      w(1);
      n++;
    end while (req_ready_o !== 1'b1 && n < 5000);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      w(1);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 100);
    chk(16'(n < 100), 16'h1);
    rd = rsp_data_o;
  endtask
  task automatic rdm(input logic [6:0] a, input logic [15:0] m, input logic [15:0] e);
    acc(1'b0, a, 16'h0);
    chk(rd & m, e);
  endtask
  task automatic clr();
    acc(1'b1, 7'h13, 16'h0001);
    w(10);
  endtask
  task automatic trip(input int k, input logic on);
    @(posedge clk_i);
    case (k)
      0: drain_ov_i <= on;
      1: vds_over_i <= {2'h0, on, 3'h0};
      2: shunt_over_i <= {2'h0, on};
      3: thermal_shutdown_i <= on;
      4: vgs_err <= {5'h0, on};
      default: thermal_warning_i <= on;
    endcase
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    resetn_i = 1'b0;
    {req_valid_i, req_wr_i, req_addr_i, req_wdata_i, pwm_hs_i, pwm_ls_i} = '0;
    {sleep_req_i, drain_ov_i, vds_over_i, shunt_over_i, phase_cmp_i} = '0;
    {thermal_shutdown_i, thermal_warning_i, vgs_err} = '0;
    // Checksum of eight zero bytes
    otp_data_i = 64'h0000000000000000;
    otp_crc_i = 8'hDB;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    w(12);
    chk(16'(crc_done_o), 16'h1);
    rdm(7'h10, 16'hFFFF, 16'h3333);
    rdm(7'h00, 16'h0010, 16'h0000);
    rdm(7'h7F, 16'hFFFF, 16'h0000);
    @(posedge clk_i) pwm_hs_i <= 3'h1;
    w(30);
    chk(16'(gate_hs_o), 16'h1);
    for (int k = 0; k < 6; k++) begin
      trip(k, 1'b1);
      w(200);
      chk(16'(fault_o), 16'(k != 5));
      chk(16'({pump_en_o, csa_en_o}), (k == 0) ? 16'h1 : (k == 3) ? 16'h0 : 16'h3);
      if (k < 4) chk(16'(gate_hs_o), 16'h0);
      trip(k, 1'b0);
      w(20);
      rdm((k == 1 || k == 4) ? 7'h01 : 7'h00, msk[k], msk[k]);
      chk(16'(fault_o), 16'(k != 5));
      clr();
      rdm((k == 1 || k == 4) ? 7'h01 : 7'h00, msk[k], 16'h0);
      w(50);
    end
    $display("fault tests done");
    @(posedge clk_i);
    resetn_i <= 1'b0;
    thermal_shutdown_i <= 1'b1;
    otp_crc_i <= 8'h00;
    w(3);
    @(posedge clk_i) resetn_i <= 1'b1;
    w(200);
    chk(16'({fault_o, pump_en_o, csa_en_o}), 16'h4);
    rdm(7'h00, 16'h0010, 16'h0010);
    @(posedge clk_i) thermal_shutdown_i <= 1'b0;
    w(20);
    chk(16'(pump_en_o), 16'h0);
    clr();
    chk(16'({fault_o, pump_en_o}), 16'h1);
    $display("power-up thermal test done");
    acc(1'b1, 7'h11, 16'h0120);
    w(10);
    chk(16'({diag_snk_o, diag_src_o, gate_hs_o}), 16'h048);
    chk(16'({pump_en_o, boot_charge_en_o}), 16'h2);
    @(posedge clk_i) vds_over_i <= 6'h01;
    w(8);
    rdm(7'h01, 16'h0040, 16'h0040);
    @(posedge clk_i) vds_over_i <= 6'h00;
    w(8);
    rdm(7'h01, 16'h0040, 16'h0000);
    acc(1'b1, 7'h11, 16'h0130);
    w(10);
    chk(16'(gate_hs_o), 16'h1);
    acc(1'b1, 7'h11, 16'h0000);
    clr();
    w(300);
    $display("diagnostic test done");
    acc(1'b1, 7'h12, 16'h0078);
    @(posedge clk_i) phase_cmp_i <= 3'h3;
    w(80);
    chk(16'({phase_cmp_o, gate_ls_o}), 16'h1E);
    rdm(7'h00, 16'h01C0, 16'h0080);
    @(posedge clk_i) phase_cmp_i <= 3'h1;
    acc(1'b1, 7'h12, 16'h0000);
    clr();
    $display("comparator test done");
    acc(1'b1, 7'h11, 16'h0009);
    w(3000);
    chk(16'(drain_ov_lvl_o), 16'h2);
    rdm(7'h00, 16'h0008, 16'h0000);
    chk(16'(fault_o), 16'h0);
    acc(1'b1, 7'h11, 16'h0000);
    $display("watchdog test done");
    @(posedge clk_i) sleep_req_i <= 1'b1;
    w(100);
    chk(16'(asleep_o), 16'h0);
    w(60);
    chk(16'({asleep_o, gate_hs_o, gate_reg_en_o}), 16'h10);
    @(posedge clk_i) sleep_req_i <= 1'b0;
    w(8);
    chk(16'(asleep_o), 16'h0);
    w(300);
    chk(16'({drive_ready_o, gate_hs_o}), 16'h9);
    $display("sleep test done");
    stop_test();
  end
endmodule
`default_nettype wire

/* File: sim/gdfm_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gdfm_regs.svh"
module gdfm_assertions (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [2:0]  hs_in,
  input  wire logic [2:0]  ls_dev_oe,
  input  wire logic        sleep_n,
  input  wire logic        spi_valid,
  input  wire logic        spi_wr,
  input  wire logic [6:0]  spi_addr,
  input  wire logic [15:0] spi_wdata,
  input  wire logic        spi_rvalid
);
  logic        en_q;
  logic [11:0] gap_q;
  logic [7:0]  wake_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // Watchdog enable, access gap, wake age
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q   <= 1'b0;
      gap_q  <= 12'h0;
      wake_q <= 8'h0;
    end else begin
      if (spi_valid && spi_wr && spi_addr == `ADDR_CFG2) en_q <= spi_wdata[0];
      gap_q  <= spi_valid ? 12'h0 : gap_q + {11'h0, gap_q != 12'hFFF};
      wake_q <= !sleep_n ? 8'h0 : wake_q + {7'h0, wake_q != 8'hFF};
    end
  end
  property p_answer; spi_valid |=> spi_rvalid; endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_lone; spi_rvalid |-> $past(spi_valid); endproperty
  a_lone: assert property (p_lone) else $error("answer without access");
  property p_hold; !spi_valid |-> $stable({spi_wr, spi_addr, spi_wdata}); endproperty
  a_hold: assert property (p_hold) else $error("access fields moved");
  property p_window; spi_valid && en_q |-> gap_q >= 12'd250; endproperty
  a_window: assert property (p_window) else $error("access too early");
  property p_alive; en_q |-> gap_q < 12'd2500; endproperty
  a_alive: assert property (p_alive) else $error("access too late");
  property p_cmp;
    spi_valid && spi_wr && spi_addr == `ADDR_CFG3 |-> ##[1:3] ls_dev_oe == {3{spi_wdata[3]}};
  endproperty
  a_cmp: assert property (p_cmp) else $error("low-side pin drive wrong");
  property p_wake_spi; spi_valid |-> sleep_n && wake_q >= 8'(`WAKE_CYC); endproperty
  a_wake_spi: assert property (p_wake_spi) else $error("access before wake");
  property p_wake_gate; $rose(hs_in != 3'h0) |-> wake_q >= 8'(`WAKE_CYC); endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("gate input before wake");
endmodule
`default_nettype wire
